//--- rtl/float_operand_classifier.sv
// Floating-point operand datapath: decodes F and L operands, checks for
// reserved forms, and runs one instruction per request in one cycle.
// Assumes the issuing CPU holds a request for one cycle and reads the
// answer in the cycle that o_done is high.
`include "fpc_defines.svh"
`default_nettype none

// Functional notes
// (RL1) Two formats: 32-bit single, 64-bit double.
// (RL2) Suffix F selects single, L double.
// (RL3) Normalized significand has hidden one, 1.0..2.0.
// (RL4) Exponent biased by 127 or 1023.
// (RL5) All-ones exponent marks a reserved operand.
// (RL6) Zero exponent: zero, or reserved if fraction.
// (RL7) Sign 1 negative; negation flips sign only.
// (RL8) Other exponents are normalized numbers.
// (RL9) Positive and negative zero both recognised.
// (RL10) Infinity, NaN, denormals are reserved operands.
// (RL11) Reserved operand traps invalid, except plain move.
// (RL12) Never deliver infinity, NaN or denormal; a move still copies such a word to o_result.
// (RL13) Round to integer: nearest, floor, toward zero.
// (RL14) Convert between formats and to/from integers.
// (RL15) Add, subtract, multiply, divide, compare with exceptions.
// (RL16) Invalid operation reports trap code 101.
// (RL17) Integers are 8, 16, 32-bit two's complement.
// (RL18) Sign on top, then exponent, then fraction.
module float_operand_classifier
  import fpc_pkg::*;
#(
  parameter int INT_W = `INT_MAX_W
)
(
  input  wire  logic             i_clk,
  input  wire  logic             i_reset_n,
  input  wire  req_s             i_req,
  output logic                   o_done,
  output logic [`DBL_W-1:0]      o_result,
  output logic [`TT_W-1:0]       o_trap_type_field,
  output logic                   o_cmp_lt,
  output logic                   o_cmp_eq
);

  if (INT_W != `INT_MAX_W)
    $error("INT_W must equal the widest integer operand");

  state_s    st_q;
  state_s    st_d;
  unpacked_s ua;
  unpacked_s ub;
  logic      dbl;

  assign dbl = (i_req.prec == PREC_L);                           // [RL2]

  operand_unpack u_unp_a (
    .i_opnd (i_req.opnd_a),
    .i_dbl  (dbl),
    .o_unp  (ua)
  );

  operand_unpack u_unp_b (
    .i_opnd (i_req.opnd_b),
    .i_dbl  (dbl),
    .o_unp  (ub)
  );

  function automatic logic is_rsvd(input cls_e c);
    is_rsvd = (c != CLS_ZERO) && (c != CLS_NORM);               // [RL10]
  endfunction

  function automatic logic [5:0] lead_shift(input word_t m);
    lead_shift = 6'h00;
    for (int i = 0; i < `DBL_W; i++)
      if (m[i])
        lead_shift = 6'(`DBL_W - 1 - i);
  endfunction

  function automatic logic [5:0] int_bits(input isize_e s);
    case (s)
      ISZ_BYTE: int_bits = `INT_BYTE_W;                          // [RL17]
      ISZ_WORD: int_bits = `INT_WORD_W;
      default:  int_bits = `INT_DWORD_W;
    endcase
  endfunction

  // Packs a normalized mantissa (msb at bit 63) into the destination
  // format. Extra bits are truncated; they only raise inexact. Results
  // out of range become the largest finite value or a positive zero, so
  // no packed result can ever be a reserved form.
  function automatic pack_s pack_result(input logic  sign,
                                        input sexp_t exp,
                                        input word_t mant,
                                        input logic  sticky,
                                        input logic  to_dbl);
    pack_s r;
    logic  inexact;
    sexp_t ef;
    r.value = '0;
    r.trap  = `TT_NONE;
    if (to_dbl)
    begin
      inexact = (|mant[`DBL_W-2-`DBL_FRAC_W:0]) | sticky;
      ef      = exp + sexp_t'(`DBL_BIAS);
      if (mant == '0)
        r.value[`DBL_SIGN] = sign;                               // [RL9]
      else if (exp > sexp_t'(`DBL_EXP_MAX))
      begin
        r.value = {sign, `DBL_MAXFIN_EF, {`DBL_FRAC_W{1'b1}}};   // [RL12]
        r.trap  = `TT_OVERFLOW;                                  // [RL15]
      end
      else if (exp < sexp_t'(`DBL_EXP_MIN))
        r.trap  = `TT_UNDERFLOW;                                 // [RL12]
      else
      begin
        r.value = {sign, ef[`DBL_EXP_W-1:0],
                   mant[`DBL_W-2 -: `DBL_FRAC_W]};               // [RL18]
        r.trap  = inexact ? `TT_INEXACT : `TT_NONE;
      end
    end
    else
    begin
      inexact = (|mant[`DBL_W-2-`SGL_FRAC_W:0]) | sticky;
      ef      = exp + sexp_t'(`SGL_BIAS);
      if (mant == '0)
        r.value[`SGL_SIGN] = sign;
      else if (exp > sexp_t'(`SGL_EXP_MAX))
      begin
        r.value[`SGL_W-1:0] = {sign, `SGL_MAXFIN_EF,
                               {`SGL_FRAC_W{1'b1}}};              // [RL12]
        r.trap  = `TT_OVERFLOW;
      end
      else if (exp < sexp_t'(`SGL_EXP_MIN))
        r.trap  = `TT_UNDERFLOW;
      else
      begin
        r.value[`SGL_W-1:0] = {sign, ef[`SGL_EXP_W-1:0],
                               mant[`DBL_W-2 -: `SGL_FRAC_W]};    // [RL1]
        r.trap  = inexact ? `TT_INEXACT : `TT_NONE;
      end
    end
    return r;
  endfunction

  // One instruction per request. The reserved-operand check comes first
  // so that no arithmetic path ever sees an infinity, NaN or denormal.
  always_comb
  begin
    pack_s                       pk;
    logic                        bad;
    logic                        sb_eff;
    logic                        a_big;
    unpacked_s                   bg;
    unpacked_s                   sm;
    sexp_t                       diff;
    sexp_t                       ex;
    word_t                       ms;
    word_t                       mant;
    word_t                       iv;
    logic                        stk;
    logic [`DBL_W:0]             sum;
    logic [2*`DBL_FRAC_W+1:0]    prod;
    logic [`DBL_FRAC_W+`DBL_W:0] num;
    logic [`DBL_FRAC_W+`DBL_W:0] quo;
    logic [`DBL_FRAC_W+`DBL_W:0] fx;
    logic [INT_W:0]              mag;
    logic [INT_W:0]              lim;
    logic                        inc;
    logic [5:0]                  sh;
    pk     = '0;
    bad    = 1'b0;
    sb_eff = ub.sign ^ (i_req.op == OP_SUB);
    a_big  = (ua.exp > ub.exp) || ((ua.exp == ub.exp) && (ua.sig >= ub.sig));
    bg     = a_big ? ua : ub;
    sm     = a_big ? ub : ua;
    diff   = bg.exp - sm.exp;
    ex     = '0;
    ms     = '0;
    mant   = '0;
    iv     = '0;
    stk    = 1'b0;
    sum    = '0;
    prod   = ua.sig * ub.sig;
    num    = {ua.sig, word_t'(0)};
    quo    = '0;
    fx     = '0;
    mag    = '0;
    lim    = '0;
    inc    = 1'b0;
    sh     = '0;
    st_d      = st_q;
    st_d.done = 1'b0;
    if (i_req.valid)
    begin
      st_d.done            = 1'b1;
      st_d.op              = i_req.op;
      st_d.dst_dbl         = (i_req.op == OP_CVT_FF) ? !dbl : dbl;
      st_d.trap_type_field = `TT_NONE;
      st_d.cmp_lt          = 1'b0;
      st_d.cmp_eq          = 1'b0;
      case (i_req.op)
        OP_MOVE, OP_INT_FLT: bad = 1'b0;
        OP_NEG, OP_CVT_FF, OP_FLT_INT: bad = is_rsvd(ua.cls);
        default: bad = is_rsvd(ua.cls) || is_rsvd(ub.cls);
      endcase
      if (bad)
      begin
        st_d.result          = '0;                               // [RL12]
        st_d.trap_type_field = `TT_INVALID;                 // [RL11] [RL16]
      end
      else
      begin
        case (i_req.op)
          // A move copies the word untouched, reserved forms included.
          OP_MOVE: pk.value = i_req.opnd_a;                      // [RL11]
          OP_NEG:
          begin
            pk.value = i_req.opnd_a;
            if (dbl)
              pk.value[`DBL_SIGN] = !ua.sign;                    // [RL7]
            else
              pk.value[`SGL_SIGN] = !ua.sign;
          end
          OP_ADD, OP_SUB:
          begin
            if (ua.cls == CLS_ZERO)
              pk = pack_result(sb_eff, ub.exp, {ub.sig, 11'h000}, 1'b0, dbl);
            else if (ub.cls == CLS_ZERO)
              pk = pack_result(ua.sign, ua.exp, {ua.sig, 11'h000}, 1'b0, dbl);
            else
            begin
              if (diff > sexp_t'(`DBL_W - 1))
                stk = 1'b1;
              else
              begin
                ms  = {sm.sig, 11'h000} >> diff[5:0];
                stk = |({sm.sig, 11'h000} & ((word_t'(1) << diff[5:0]) - 1));
              end
              sum = ((a_big ? ua.sign : sb_eff) != (a_big ? sb_eff : ua.sign))
                    ? {1'b0, bg.sig, 11'h000} - {1'b0, ms}
                    : {1'b0, bg.sig, 11'h000} + {1'b0, ms};       // [RL15]
              if (sum[`DBL_W])
              begin
                mant = sum[`DBL_W:1];
                stk  = stk | sum[0];
                ex   = bg.exp + sexp_t'(1);
              end
              else
              begin
                sh   = lead_shift(sum[`DBL_W-1:0]);
                mant = sum[`DBL_W-1:0] << sh;
                ex   = bg.exp - sexp_t'(sh);
              end
              pk = pack_result(a_big ? ua.sign : sb_eff, ex, mant, stk, dbl);
            end
          end
          OP_MUL:
          begin
            if (prod[2*`DBL_FRAC_W+1])
            begin
              mant = prod[2*`DBL_FRAC_W+1 -: `DBL_W];
              ex   = ua.exp + ub.exp + sexp_t'(1);
            end
            else
            begin
              mant = prod[2*`DBL_FRAC_W -: `DBL_W];
              ex   = ua.exp + ub.exp;
            end
            stk = |prod[2*`DBL_FRAC_W-`DBL_W+1:0];
            if (ua.cls == CLS_ZERO || ub.cls == CLS_ZERO)
              mant = '0;
            pk = pack_result(ua.sign ^ ub.sign, ex, mant, stk, dbl);
          end
          OP_DIV:
          begin
            if (ub.cls == CLS_ZERO)
              pk.trap = (ua.cls == CLS_ZERO) ? `TT_INVALID : `TT_DIVZERO;
            else
            begin
              quo = num / (`DBL_FRAC_W+`DBL_W+1)'(ub.sig);
              stk = (num % (`DBL_FRAC_W+`DBL_W+1)'(ub.sig)) != '0;
              mant = quo[`DBL_W] ? quo[`DBL_W:1] : quo[`DBL_W-1:0];
              stk  = stk | (quo[`DBL_W] & quo[0]);
              ex   = ua.exp - ub.exp - sexp_t'(!quo[`DBL_W]);
              pk   = pack_result(ua.sign ^ ub.sign, ex, mant, stk, dbl);
            end
          end
          OP_CMP:
          begin
            pk.value = st_q.result;
            if (ua.cls == CLS_ZERO && ub.cls == CLS_ZERO)
              st_d.cmp_eq = 1'b1;                                // [RL9]
            else if (ua.sign != ub.sign)
              st_d.cmp_lt = ua.sign;
            else
            begin
              st_d.cmp_eq = (ua.exp == ub.exp) && (ua.sig == ub.sig);
              st_d.cmp_lt = ((ua.exp < ub.exp) ||
                            ((ua.exp == ub.exp) && (ua.sig < ub.sig)))
                            ^ ua.sign;
              st_d.cmp_lt = st_d.cmp_lt && !st_d.cmp_eq;         // [RL15]
            end
          end
          OP_CVT_FF:
            pk = pack_result(ua.sign, ua.exp, {ua.sig, 11'h000}, 1'b0,
                             !dbl);                              // [RL14]
          OP_FLT_INT:
          begin
            // Small magnitudes keep only a sticky bit below one half.
            if (ua.exp > sexp_t'(INT_W - 1))
              pk.trap = `TT_OVERFLOW;
            else if (ua.cls != CLS_ZERO && ua.exp < sexp_t'(-1))
              fx[0] = 1'b1;
            else if (ua.cls != CLS_ZERO)
              fx = num >> (`DBL_FRAC_W - ua.exp);
            case (i_req.rnd)                                     // [RL13]
              RND_NEAREST: inc = fx[`DBL_W-1] &
                                 ((|fx[`DBL_W-2:0]) | fx[`DBL_W]);
              RND_FLOOR:   inc = ua.sign & (|fx[`DBL_W-1:0]);
              default:     inc = 1'b0;
            endcase
            mag = fx[`DBL_W +: INT_W+1] + (INT_W+1)'(inc);
            lim = (INT_W+1)'(1) << (int_bits(i_req.isize) - 6'h01);
            iv  = ua.sign ? -word_t'(mag) : word_t'(mag);        // [RL17]
            if (pk.trap == `TT_NONE)
            begin
              if (ua.sign ? (mag > lim) : (mag >= lim))
                pk.trap = `TT_OVERFLOW;
              else
              begin
                pk.value = iv;
                pk.trap  = (|fx[`DBL_W-1:0]) ? `TT_INEXACT : `TT_NONE;
              end
            end
          end
          OP_INT_FLT:
          begin
            sh   = 6'(`DBL_W) - int_bits(i_req.isize);
            iv   = word_t'($signed(i_req.opnd_a << sh) >>> sh);  // [RL17]
            mant = iv[`DBL_SIGN] ? -iv : iv;
            sh   = lead_shift(mant);
            pk   = pack_result(iv[`DBL_SIGN], sexp_t'(`DBL_W - 1) -
                               sexp_t'(sh), mant << sh, 1'b0, dbl); // [RL14]
          end
          default: pk.trap = `TT_NONE;
        endcase
        st_d.result          = pk.value;
        st_d.trap_type_field = pk.trap;
      end
    end
  end

  // Synchronous reset; the answer registers hold until the next request.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign o_done            = st_q.done;
  assign o_result          = st_q.result;
  assign o_trap_type_field = st_q.trap_type_field;
  assign o_cmp_lt          = st_q.cmp_lt;
  assign o_cmp_eq          = st_q.cmp_eq;

  // Checks on the classification and on the registered answer.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  logic a_ones;
  assign a_ones = dbl ? (&i_req.opnd_a[`DBL_SIGN-1 -: `DBL_EXP_W])
                      : (&i_req.opnd_a[`SGL_SIGN-1 -: `SGL_EXP_W]);

  rsvd_trap_a: assert property (i_req.valid && a_ones &&    // [RL11]
    i_req.op != OP_MOVE && i_req.op != OP_INT_FLT |=> o_done &&
    o_trap_type_field == `TT_INVALID) else $error("reserved not trapped");
  move_pass_a: assert property (i_req.valid && i_req.op == OP_MOVE // [RL11]
    |=> o_result == $past(i_req.opnd_a) && o_trap_type_field == `TT_NONE)
    else $error("move altered operand");
  // Either precision: only the sign bit of that format may differ.
  neg_sign_a: assert property (i_req.valid && i_req.op == OP_NEG && // [RL7]
    ua.cls == CLS_NORM |=> (o_result ^ $past(i_req.opnd_a)) ==
    (word_t'(1) << ($past(dbl) ? `DBL_SIGN : `SGL_SIGN)))
    else $error("negate changed more than sign");
  no_rsvd_out_a: assert property (o_done && st_q.dst_dbl && // [RL12]
    st_q.op inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_CVT_FF}
    |-> !(&o_result[`DBL_SIGN-1 -: `DBL_EXP_W]))
    else $error("reserved result delivered");
  zero_class_a: assert property (i_req.valid && dbl && // [RL9]
    i_req.opnd_a[`DBL_SIGN-1:0] == '0 |-> ua.cls == CLS_ZERO)
    else $error("zero misclassified");
  denorm_class_a: assert property (i_req.valid && !dbl && // [RL6]
    i_req.opnd_a[`SGL_SIGN-1 -: `SGL_EXP_W] == '0 &&
    i_req.opnd_a[`SGL_FRAC_W-1:0] != '0 |-> ua.cls == CLS_DENORM)
    else $error("denormal misclassified");
  bias_a: assert property (i_req.valid && dbl && ua.cls == CLS_NORM // [RL4]
    |-> ua.exp == sexp_t'(i_req.opnd_a[`DBL_SIGN-1 -: `DBL_EXP_W]) -
    sexp_t'(`DBL_BIAS)) else $error("bias wrong");
  hidden_one_a: assert property (i_req.valid && !dbl && // [RL3]
    ua.cls == CLS_NORM |-> ua.sig[`DBL_FRAC_W] &&
    ua.sig[`DBL_FRAC_W-1 -: `SGL_FRAC_W] == i_req.opnd_a[`SGL_FRAC_W-1:0])
    else $error("significand wrong");
  div_zero_a: assert property (i_req.valid && i_req.op == OP_DIV && // [RL15]
    ua.cls == CLS_NORM && ub.cls == CLS_ZERO
    |=> o_trap_type_field == `TT_DIVZERO) else $error("divide by zero lost");
  done_pulse_a: assert property (!i_req.valid |=> !o_done) // [RL2]
    else $error("done without request");

  add_seen_c: cover property (i_req.valid && i_req.op == OP_ADD ##1 o_done);
  invalid_seen_c: cover property (o_done &&
    o_trap_type_field == `TT_INVALID);
  round_seen_c: cover property (i_req.valid && i_req.op == OP_FLT_INT &&
    i_req.rnd == RND_NEAREST);

endmodule // float_operand_classifier

`default_nettype wire

//--- rtl/fpc_defines.svh
// Constants of the floating-point operand classifier: formats, biases,
// exponent limits, trap codes and integer widths.
// Assumes it is included by the package and by the design modules.
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH

// Formats: sign at the top, then exponent, then fraction.
`define SGL_W          32
`define DBL_W          64
`define SGL_EXP_W      8
`define DBL_EXP_W      11
`define SGL_FRAC_W     23
`define DBL_FRAC_W     52
`define SGL_SIGN       31
`define DBL_SIGN       63
`define EXP_CALC_W     14

// Exponent biases and the legal range of true exponents.
`define SGL_BIAS       14'h007f
`define DBL_BIAS       14'h03ff
`define SGL_EXP_MAX    14'h007f
`define SGL_EXP_MIN    14'h3f82
`define DBL_EXP_MAX    14'h03ff
`define DBL_EXP_MIN    14'h3c02

// Largest finite exponent fields, used when a result overflows.
`define SGL_MAXFIN_EF  8'hfe
`define DBL_MAXFIN_EF  11'h7fe

// Trap type field codes.
`define TT_W           3
`define TT_NONE        3'h0
`define TT_UNDERFLOW   3'h1
`define TT_OVERFLOW    3'h2
`define TT_DIVZERO     3'h3
`define TT_INVALID     3'h5
`define TT_INEXACT     3'h6

// Two's complement integer widths.
`define INT_BYTE_W     6'h08
`define INT_WORD_W     6'h10
`define INT_DWORD_W    6'h20
`define INT_MAX_W      32

`endif

//--- rtl/fpc_pkg.sv
// Types shared by the operand classifier and its unpacking module.
// Assumes fpc_defines.svh is on the include path.
`include "fpc_defines.svh"
`default_nettype none

package fpc_pkg;

  typedef enum logic [3:0] {
    OP_MOVE, OP_NEG, OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_CMP,
    OP_CVT_FF, OP_FLT_INT, OP_INT_FLT
  } op_e;

  // Precision suffix of the instruction: F is single, L is double.
  typedef enum logic {PREC_F, PREC_L} prec_e;

  typedef enum logic [1:0] {RND_NEAREST, RND_FLOOR, RND_TRUNC} rnd_e;
  typedef enum logic [1:0] {ISZ_BYTE, ISZ_WORD, ISZ_DWORD} isize_e;
  typedef enum logic [2:0] {
    CLS_ZERO, CLS_NORM, CLS_INF, CLS_NAN, CLS_DENORM
  } cls_e;

  typedef logic [`DBL_W-1:0]             word_t;
  typedef logic signed [`EXP_CALC_W-1:0] sexp_t;

  typedef struct packed {
    logic   valid;
    op_e    op;
    prec_e  prec;
    rnd_e   rnd;
    isize_e isize;
    word_t  opnd_a;
    word_t  opnd_b;
  } req_s;

  typedef struct packed {
    logic                 sign;
    sexp_t                exp;
    logic [`DBL_FRAC_W:0] sig;
    cls_e                 cls;
  } unpacked_s;

  typedef struct packed {
    word_t            value;
    logic [`TT_W-1:0] trap;
  } pack_s;

  typedef struct packed {
    logic             done;
    word_t            result;
    logic [`TT_W-1:0] trap_type_field;
    logic             cmp_lt;
    logic             cmp_eq;
    op_e              op;
    logic             dst_dbl;
  } state_s;

endpackage

`default_nettype wire

//--- rtl/operand_unpack.sv
// Splits one operand into sign, true exponent and significand, and
// classifies it. Purely combinational.
// Assumes single operands sit in the low 32 bits of the operand word.
`include "fpc_defines.svh"
`default_nettype none

module operand_unpack
  import fpc_pkg::*;
(
  input  wire word_t     i_opnd,
  input  wire logic      i_dbl,
  output var  unpacked_s o_unp
);

  // Field split and classification; the hidden one is dropped only for a
  // zero exponent so that zero carries an all-zero significand.
  always_comb
  begin
    logic [`DBL_EXP_W-1:0]  ef;
    logic [`DBL_FRAC_W-1:0] ff;
    logic                   ones;
    sexp_t                  bias;
    ef   = '0;
    ff   = '0;
    ones = 1'b0;
    bias = sexp_t'(`DBL_BIAS);
    if (i_dbl)
    begin
      o_unp.sign = i_opnd[`DBL_SIGN];                            // [RL18]
      ef         = i_opnd[`DBL_SIGN-1 -: `DBL_EXP_W];
      ff         = i_opnd[`DBL_FRAC_W-1:0];
      ones       = &i_opnd[`DBL_SIGN-1 -: `DBL_EXP_W];
    end
    else
    begin
      o_unp.sign = i_opnd[`SGL_SIGN];                            // [RL18]
      ef         = `DBL_EXP_W'(i_opnd[`SGL_SIGN-1 -: `SGL_EXP_W]);
      ff         = {i_opnd[`SGL_FRAC_W-1:0],
                    (`DBL_FRAC_W-`SGL_FRAC_W)'(0)};
      ones       = &i_opnd[`SGL_SIGN-1 -: `SGL_EXP_W];
      bias       = sexp_t'(`SGL_BIAS);
    end
    o_unp.exp = sexp_t'(ef) - bias;                              // [RL4]
    o_unp.sig = {1'b1, ff};                                      // [RL3]
    if (ones)
      o_unp.cls = (ff == '0) ? CLS_INF : CLS_NAN;           // [RL5] [RL10]
    else if (ef == '0)
    begin
      // Both signed zeros land here; the sign stays as given.
      o_unp.cls = (ff == '0) ? CLS_ZERO : CLS_DENORM;       // [RL6] [RL9]
      o_unp.sig = {1'b0, ff};
    end
    else
      o_unp.cls = CLS_NORM;                                      // [RL8]
  end

endmodule // operand_unpack

`default_nettype wire

//--- testbench/float_operand_classifier_tb.sv
// Self-checking bench of the operand classifier: a table of instructions,
// then back-to-back issue and a reset in mid-run.
// Assumes the CPU model adds one cycle before each request.
`default_nettype none

module float_operand_classifier_tb
  import fpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    req_s       r;
    word_t      res;
    logic [2:0] t;
  } row_s;

  localparam word_t one_f     = 64'h3f80_0000;
  localparam word_t one_l     = 64'h3ff0_0000_0000_0000;
  localparam word_t neg_one_f = 64'hbf80_0000;
  localparam word_t neg_1p5   = 64'hbfc0_0000;
  localparam word_t neg_two   = 64'hffff_ffff_ffff_fffe;

  logic       i_clk = 1'b0;
  logic       i_reset_n;
  logic       i_issue;
  req_s       cmd;
  req_s       req;
  logic       o_done;
  word_t      o_result;
  logic [2:0] o_trap_type_field;
  logic       o_cmp_lt;
  logic       o_cmp_eq;
  row_s       rows[$];
  rnd_e       rn;
  isize_e     sz;
  int         error_cnt = 0;
  int         compares = 0;

  always #5 i_clk = ~i_clk;

  host_cpu_model i_host (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_issue(i_issue), .i_cmd(cmd), .o_req(req));

  float_operand_classifier #(.INT_W(32)) i_dut (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_req(req), .o_done(o_done),
    .o_result(o_result), .o_trap_type_field(o_trap_type_field),
    .o_cmp_lt(o_cmp_lt), .o_cmp_eq(o_cmp_eq));

  task automatic end_sim();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input word_t e, input word_t g);
    compares++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  task automatic add(input op_e op, input prec_e p, input word_t a,
                     input word_t b, input word_t res, input logic [2:0] t);
    rows.push_back(row_s'{req_s'{1'b1, op, p, rn, sz, a, b}, res, t});
  endtask

  // One request at the next edge; the model presents it an edge later.
  task automatic send(input req_s r);
    @(posedge i_clk);
    i_issue <= 1'b1;
    cmd     <= r;
  endtask

  // Compare items only exist for CMP, so the result word holds lt and eq.
  task automatic check(input row_s w);
    chk("done", 64'h1, 64'(o_done));
    if (w.r.op == OP_CMP)
      chk("cmp", w.res, 64'({o_cmp_lt, o_cmp_eq}));
    else
      chk("result", w.res, o_result);
    chk("trap", 64'(w.t), 64'(o_trap_type_field));
  endtask

  // The whole run is under a hundred cycles; this cuts off a hang.
  initial
  begin
    repeat (2000) @(posedge i_clk);
    error_cnt++;
    end_sim();
  end

  initial
  begin
    i_reset_n = 1'b0;
    i_issue   = 1'b0;
    cmd       = '0;
    rn        = RND_NEAREST;
    sz        = ISZ_DWORD;
    repeat (3) @(posedge i_clk);
    #1 chk("reset result", 64'h0, o_result);
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    add(OP_ADD, PREC_F, one_f, one_f, 64'h4000_0000, 3'h0);
    add(OP_MUL, PREC_F, 64'h3fc0_0000, 64'h4000_0000, 64'h4040_0000,
        3'h0);
    add(OP_SUB, PREC_L, 64'h4000_0000_0000_0000, one_l, one_l,
        3'h0);
    add(OP_ADD, PREC_F, 64'h7f80_0000, one_f, 64'h0, 3'h5);
    add(OP_ADD, PREC_L, 64'h7ff8_0000_0000_0000, one_l, 64'h0,
        3'h5);
    add(OP_ADD, PREC_F, 64'h0000_0001, one_f, 64'h0, 3'h5);
    add(OP_MOVE, PREC_F, 64'h7fc0_0000, one_f, 64'h7fc0_0000,
        3'h0);
    add(OP_NEG, PREC_F, one_f, 64'h0, neg_one_f, 3'h0);
    add(OP_CMP, PREC_F, 64'h8000_0000, 64'h0, 64'h1, 3'h0);
    add(OP_CMP, PREC_F, neg_one_f, one_f, 64'h2, 3'h0);
    add(OP_CMP, PREC_L, 64'h8000_0000_0000_0000, 64'h0, 64'h1, 3'h0);
    add(OP_DIV, PREC_F, one_f, 64'h0, 64'h0, 3'h3);
    add(OP_DIV, PREC_F, 64'h0, 64'h0, 64'h0, 3'h5);
    add(OP_ADD, PREC_F, 64'h7f7f_ffff, 64'h7f7f_ffff, 64'h7f7f_ffff,
        3'h2);
    add(OP_MUL, PREC_F, 64'h0080_0000, 64'h0080_0000, 64'h0,
        3'h1);
    add(OP_CVT_FF, PREC_F, one_f, 64'h0, one_l, 3'h0);
    add(OP_FLT_INT, PREC_F, neg_1p5, 64'h0, neg_two, 3'h6);
    rn = RND_FLOOR;
    add(OP_FLT_INT, PREC_F, neg_1p5, 64'h0, neg_two, 3'h6);
    rn = RND_TRUNC;
    add(OP_FLT_INT, PREC_F, neg_1p5, 64'h0, ~64'h0, 3'h6);
    add(OP_INT_FLT, PREC_F, 64'hffff_ffff, 64'h0, neg_one_f, 3'h0);
    sz = ISZ_WORD;
    add(OP_INT_FLT, PREC_F, 64'hffff, 64'h0, neg_one_f, 3'h0);
    sz = ISZ_BYTE;
    add(OP_INT_FLT, PREC_F, 64'h00ff, 64'h0, neg_one_f, 3'h0);
    foreach (rows[i])
    begin
      send(rows[i].r);
      @(posedge i_clk);
      i_issue <= 1'b0;
      @(posedge i_clk);
      #1 check(rows[i]);
    end
    // Two requests on consecutive edges must each answer once.
    send(rows[0].r);
    send(rows[7].r);
    @(posedge i_clk);
    i_issue <= 1'b0;
    #1 check(rows[0]);
    @(posedge i_clk);
    #1 check(rows[7]);
    @(posedge i_clk);
    #1 chk("done low", 64'h0, 64'(o_done));
    chk("held result", neg_one_f, o_result);
    // A reset in mid-run clears the answer; the next request works.
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    @(posedge i_clk);
    #1 chk("reset trap", 64'h0, 64'(o_trap_type_field));
    chk("mid reset result", 64'h0, o_result);
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    send(rows[3].r);
    @(posedge i_clk);
    i_issue <= 1'b0;
    @(posedge i_clk);
    #1 check(rows[3]);
    end_sim();
  end
endmodule // float_operand_classifier_tb

`default_nettype wire

//--- testbench/host_cpu_model.sv
// Model of the issuing CPU: turns one bench command into a one-cycle
// request on the classifier's request port.
// Assumes the bench drives i_issue and i_cmd at the rising clock edge.
`default_nettype none

module host_cpu_model
  import fpc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_issue,
  input  wire req_s i_cmd,
  output var  req_s o_req
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle cycles flip the operands, so a stale request cannot pass by luck.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_req <= '0;
    end
    else if (i_issue)
    begin
      o_req       <= i_cmd;  // Single operands ride in the low word.
      o_req.valid <= 1'b1;
    end
    else
    begin
      o_req.valid  <= 1'b0;
      o_req.opnd_a <= ~o_req.opnd_a;
      o_req.opnd_b <= ~o_req.opnd_b;
    end
  end
endmodule // host_cpu_model

`default_nettype wire
